/* File: bench/ref_clock_pair.sv */
// Model of the two reference clock sources that feed the switchover multiplexer.
`timescale 1ns/1ps
module ref_clock_pair #(
   parameter int HALF_A = 6,
   parameter int HALF_B = 8
) (
   input wire logic clk,
   input wire logic [1:0] stop,
   input wire logic stop_level,
   output logic clock_in_a,
   output logic clock_in_b
);
   logic [1:0] level = 2'h0;
   int cnt [2] = '{0, 0};
   localparam int HALF [2] = '{HALF_A, HALF_B};
   assign clock_in_a = level[0];
   assign clock_in_b = level[1];
   // ----------------------------------------------------------------
   // Source generation
   // ----------------------------------------------------------------
   // ratio within limit
   // Half periods of six and eight cycles give a 4:3 ratio, far below half the system rate.
   always @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         if (stop[i]) begin
            level[i] <= stop_level;
            cnt[i] <= 0;
         end else if (cnt[i] == HALF[i] - 1) begin
            level[i] <= ~level[i];
            cnt[i] <= 0;
         end else begin
            cnt[i] <= cnt[i] + 1;
         end
      end
   end
endmodule // ref_clock_pair

/* File: bench/testbench.sv */
// Self-checking testbench for the glitch-guarded clock switchover multiplexer.
`timescale 1ns/1ps
module testbench;
   logic CLK = 1'b0;
   logic SRST = 1'b1;
   logic SEL = 1'b0;
   logic EN = 1'b1;
   logic GUARD_DISABLE_STRAP = 1'b0;
   logic [1:0] stop = 2'h0;
   logic stop_level = 1'b0;
   logic in_a;
   logic in_b;
   logic [9:0] Q;
   logic [9:0] Q_N;
   logic busy;
   int miscompares = 0;
   int n_compared = 0;
   always #5 CLK = ~CLK;
   ref_clock_pair #(.HALF_A(6), .HALF_B(8)) src (.clk(CLK), .stop(stop), .stop_level(stop_level),
      .clock_in_a(in_a), .clock_in_b(in_b));
   clock_switch_mux DUT (.CLK(CLK), .SRST(SRST), .CLOCK_IN_A(in_a), .CLOCK_IN_B(in_b), .SEL(SEL), .EN(EN),
      .GUARD_DISABLE_STRAP(GUARD_DISABLE_STRAP), .Q(Q), .Q_N(Q_N), .SWITCH_BUSY(busy));
   // ----------------------------------------------------------------
   // Shared checks
   // ----------------------------------------------------------------
   task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Output copies track the selected source one cycle late.
   task automatic follow(input int n);
      logic prev;
      @(negedge CLK);
      prev = SEL ? in_b : in_a;
      repeat (n) begin
         @(negedge CLK);
         check(Q, {10{prev}}, "output does not track source");
         check(Q_N, {10{~prev}}, "complement does not track source");
         prev = SEL ? in_b : in_a;
      end
   endtask
   // Guarded hand-over: bounded length and no pulse shorter than a source half period.
   task automatic switch_to(input logic s, input logic old_high);
      int t;
      int run;
      int min_run;
      logic last;
      t = 0;
      run = 1000;
      min_run = 1000;
      @(posedge CLK);
      SEL <= s;
      repeat (3) @(negedge CLK);
      last = Q[0];
      check(10'(busy), 10'h1, "hand-over not started");
      if (old_high) begin
         check(Q, 10'h3FF, "output not held high");
      end
      while (busy === 1'b1 && t < 275) begin
         @(negedge CLK);
         t++;
         if (Q[0] === last) begin
            run++;
         end else begin
            if (run < min_run) min_run = run;
            run = 1;
            last = Q[0];
         end
      end
      check(10'(t < 275), 10'h1, "hand-over too long");
      check(10'(min_run >= 6), 10'h1, "runt pulse in hand-over");
      follow(40);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic reset_state();
      repeat (10) @(negedge CLK);
      check(Q, 10'h000, "output not low in reset");
      check(Q_N, 10'h3FF, "complement not high in reset");
   endtask
   task automatic loss_hold();
      @(posedge CLK);
      stop_level <= 1'b0;
      stop <= 2'h2;
      follow(40);
      stop <= 2'h0;
   endtask
   task automatic enable_gate();
      @(posedge CLK);
      EN <= 1'b0;
      repeat (20) @(negedge CLK);
      repeat (30) begin
         @(negedge CLK);
         check(Q, 10'h000, "output not gated low");
         check(Q_N, 10'h3FF, "complement not gated high");
      end
      @(posedge CLK);
      EN <= 1'b1;
      repeat (20) @(negedge CLK);
      follow(30);
   endtask
   task automatic bypass();
      @(posedge CLK);
      GUARD_DISABLE_STRAP <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         @(posedge CLK);
         SEL <= ~SEL;
         repeat (3) @(negedge CLK);
         follow(30);
      end
   endtask
   initial begin
      reset_state();
      repeat (2) @(posedge CLK);
      SRST <= 1'b0;
      repeat (40) @(posedge CLK);
      follow(30);
      switch_to(1'b1, 1'b0);
      switch_to(1'b0, 1'b0);
      @(posedge CLK);
      stop_level <= 1'b1;
      stop <= 2'h1;
      repeat (20) @(posedge CLK);
      switch_to(1'b1, 1'b1);
      stop <= 2'h0;
      loss_hold();
      enable_gate();
      bypass();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge CLK);
      miscompares++;
      print_verdict();
   end
endmodule // testbench

/* File: hw/clock_mux_defines.svh */
// Constants for the glitch-guarded two-input clock switchover multiplexer.
`ifndef CLOCK_MUX_DEFINES_SVH
`define CLOCK_MUX_DEFINES_SVH
`define FANOUT_COUNT 10
`define SWITCH_LIMIT_CYCLES 17
`define OLD_PULSES 2
`define LOW_PULSES 2
`define HIGH_PULSES 2
`define STUCK_LIMIT 8
`define CNT_W 4
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define AGE_W 5
`define AGE_ZERO 5'h00
`define AGE_ONE 5'h01
`define AGE_MAX 5'h1F
`endif

/* File: hw/clock_mux_pkg.sv */
// Types for the glitch-guarded two-input clock switchover multiplexer.
package clock_mux_pkg;
   typedef enum logic [4:0] {
      ST_FOLLOW = 5'h01,
      ST_OLD = 5'h02,
      ST_LOW = 5'h04,
      ST_HIGH = 5'h08,
      ST_FALL = 5'h10
   } hand_state_t;
endpackage

/* File: hw/clock_switch_mux.sv */
// Top of the glitch-guarded two-input clock switchover multiplexer with ten output copies.
// Notes on behaviour
// - With the guard active the output follows the new clock within 17 falling edges of the new clock after a select change.
// - With the disable strap high the block is a plain multiplexer that switches at once.
// - Both inputs use the same hand-over sequence, so either may be the primary.
// - When the selected input stops toggling the output holds its last valid level.
// - After a select change the old clock is still passed for a few of its pulses.
// - The output is then held low for a few pulses of the new clock.
// - Finally the new clock is passed continuously.
// - If the old clock is stuck high the output first stays high for a few new-clock pulses.
// - It then goes low until the next new-clock falling edge and afterwards passes the new clock.
// - Select is synchronised in two stages, so stage lengths vary within limits.
// - With the guard active, output enable acts only at a falling edge of the selected input; disabled gives true low, complement high.
// - Reset puts the switchover logic into a known state.
`timescale 1ns/1ps
`include "clock_mux_defines.svh"
module clock_switch_mux (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CLOCK_IN_A,
   input wire logic CLOCK_IN_B,
   input wire logic SEL,
   input wire logic EN,
   input wire logic GUARD_DISABLE_STRAP,
   output logic [`FANOUT_COUNT-1:0] Q,
   output logic [`FANOUT_COUNT-1:0] Q_N,
   output logic SWITCH_BUSY
);
   // ------------------------------------------------------------
   // Select synchroniser and input watchers
   // ------------------------------------------------------------
   logic sel_meta_q;
   logic sel_sync_q;
   logic rise_a, fall_a, stuck_a;
   logic rise_b, fall_b, stuck_b;
   // Select may change at any moment, so only the second stage is ever read by the hand-over logic.
   // This costs two system cycles of latency before a hand-over starts.
   // two-stage select synchroniser
   always_ff @(posedge CLK) begin
      if (SRST) begin
         sel_meta_q <= 1'b0;
         sel_sync_q <= 1'b0;
      end else begin
         sel_meta_q <= SEL;
         sel_sync_q <= sel_meta_q;
      end
   end
   edge_watch watch_a (
      .CLK(CLK),
      .SRST(SRST),
      .clk_in(CLOCK_IN_A),
      .rise(rise_a),
      .fall(fall_a),
      .stuck(stuck_a),
      .level_q()
   );
   edge_watch watch_b (
      .CLK(CLK),
      .SRST(SRST),
      .clk_in(CLOCK_IN_B),
      .rise(rise_b),
      .fall(fall_b),
      .stuck(stuck_b),
      .level_q()
   );
   // ------------------------------------------------------------
   // Hand-over state machine
   // ------------------------------------------------------------
   clock_mux_pkg::hand_state_t state_q, state_d;
   logic cur_q, cur_d;
   logic [`CNT_W-1:0] cnt_q, cnt_d;
   logic out_q, out_d;
   logic en_q, en_d;
   logic [`AGE_W-1:0] age_q, age_d;
   logic old_lvl, old_fall, old_stuck, new_rise, new_fall, sel_lvl, sel_fall, sel_stuck;
   // Picks the signal of input B when the select bit is high, else that of input A.
   function automatic logic pick(input logic s, input logic a, input logic b);
      pick = s ? b : a;
   endfunction
   always_comb begin
      // The live input level is passed, so the output lags its source by exactly one register stage.
      old_lvl = pick(cur_q, CLOCK_IN_A, CLOCK_IN_B);
      old_fall = pick(cur_q, fall_a, fall_b);
      old_stuck = pick(cur_q, stuck_a, stuck_b);
      // In bypass the raw select is used on purpose, so the source changes at the very next edge.
      new_rise = pick(sel_sync_q, rise_a, rise_b);
      new_fall = pick(sel_sync_q, fall_a, fall_b);
      sel_lvl = GUARD_DISABLE_STRAP ? pick(SEL, CLOCK_IN_A, CLOCK_IN_B) : old_lvl;
      sel_fall = pick(cur_q, fall_a, fall_b);
      sel_stuck = old_stuck;
      state_d = state_q;
      cur_d = cur_q;
      cnt_d = cnt_q;
      out_d = out_q;
      if (GUARD_DISABLE_STRAP) begin
         state_d = clock_mux_pkg::ST_FOLLOW;
         cur_d = SEL;
         out_d = sel_lvl;
         cnt_d = `CNT_ZERO;
      end else begin
         case (state_q)
            clock_mux_pkg::ST_FOLLOW: begin
               // hold last level when input lost
               out_d = sel_stuck ? out_q : old_lvl;
               // A stuck old clock skips the old-pulse stage: high goes through the high stage,
               // low goes straight to waiting for a falling edge of the new clock.
               cnt_d = `CNT_ZERO;
               if (sel_sync_q != cur_q) begin
                  if (old_stuck && old_lvl) begin
                     state_d = clock_mux_pkg::ST_HIGH;
                     out_d = 1'b1;
                  end else if (old_stuck) begin
                     state_d = clock_mux_pkg::ST_FALL;
                     out_d = 1'b0;
                  end else begin
                     state_d = clock_mux_pkg::ST_OLD;
                  end
               end
            end
            clock_mux_pkg::ST_OLD: begin
               // keep old clock for a few pulses
               out_d = old_lvl;
               if (old_fall) begin
                  cnt_d = cnt_q + `CNT_ONE;
               end
               if (old_fall && cnt_q + `CNT_ONE >= `CNT_W'(`OLD_PULSES) || old_stuck) begin
                  state_d = clock_mux_pkg::ST_LOW;
                  out_d = 1'b0;
                  cnt_d = `CNT_ZERO;
               end
            end
            clock_mux_pkg::ST_LOW: begin
               // hold low for new-clock pulses
               // Leaving on a new-clock fall lets this low stretch merge with the new low half period.
               out_d = 1'b0;
               if (new_fall) begin
                  cnt_d = cnt_q + `CNT_ONE;
                  if (cnt_q + `CNT_ONE >= `CNT_W'(`LOW_PULSES)) begin
                     state_d = clock_mux_pkg::ST_FOLLOW;
                     cur_d = sel_sync_q;
                  end
               end
            end
            clock_mux_pkg::ST_HIGH: begin
               out_d = 1'b1;
               if (new_rise) begin
                  cnt_d = cnt_q + `CNT_ONE;
                  if (cnt_q + `CNT_ONE >= `CNT_W'(`HIGH_PULSES)) begin
                     state_d = clock_mux_pkg::ST_FALL;
                     out_d = 1'b0;
                     cnt_d = `CNT_ZERO;
                  end
               end
            end
            clock_mux_pkg::ST_FALL: begin
               out_d = 1'b0;
               if (new_fall) begin
                  state_d = clock_mux_pkg::ST_FOLLOW;
                  cur_d = sel_sync_q;
                  cnt_d = `CNT_ZERO;
               end
            end
            default: begin
               state_d = clock_mux_pkg::ST_FOLLOW;
               out_d = 1'b0;
            end
         endcase
      end
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_q <= clock_mux_pkg::ST_FOLLOW;
         cur_q <= 1'b0;
         cnt_q <= `CNT_ZERO;
         out_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cur_q <= cur_d;
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end
   // ------------------------------------------------------------
   // Output enable
   // ------------------------------------------------------------
   // The enable is taken at the edge where the output itself goes low, so EN never cuts a pulse.
   // In bypass there is no hand-over to protect, so EN is taken at every edge.
   // enable at falling edge
   always_comb begin
      en_d = en_q;
      if (GUARD_DISABLE_STRAP || sel_fall) begin
         en_d = EN;
      end
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         en_q <= 1'b0;
      end else begin
         en_q <= en_d;
      end
   end
   // ------------------------------------------------------------
   // Hand-over length
   // ------------------------------------------------------------
   // Counts falling edges of the new clock while a hand-over runs; it saturates so it never wraps.
   // hand-over length count
   always_comb begin
      age_d = age_q;
      if (state_q == clock_mux_pkg::ST_FOLLOW) begin
         age_d = `AGE_ZERO;
      end else if (new_fall && age_q != `AGE_MAX) begin
         age_d = age_q + `AGE_ONE;
      end
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         age_q <= `AGE_ZERO;
      end else begin
         age_q <= age_d;
      end
   end
   // ------------------------------------------------------------
   // Fanout
   // ------------------------------------------------------------
   // ten identical gated copies
   always_comb begin
      Q = {`FANOUT_COUNT{out_q & en_q}};
      Q_N = ~Q;
   end
   assign SWITCH_BUSY = (state_q != clock_mux_pkg::ST_FOLLOW) || (sel_sync_q != cur_q);
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   fanout_same_a: assert property (@(posedge CLK) disable iff (SRST) (Q == {`FANOUT_COUNT{Q[0]}}) && (Q_N == ~Q))
      else $error("fanout copies differ");
   bypass_mux_a: assert property (@(posedge CLK) disable iff (SRST)
      GUARD_DISABLE_STRAP && $past(GUARD_DISABLE_STRAP) |-> out_q == $past(pick(SEL, CLOCK_IN_A, CLOCK_IN_B)))
      else $error("bypass output wrong");
   low_stage_a: assert property (@(posedge CLK) disable iff (SRST)
      state_q == clock_mux_pkg::ST_LOW && !GUARD_DISABLE_STRAP |=> out_q == 1'b0)
      else $error("low stage not low");
   high_stage_a: assert property (@(posedge CLK) disable iff (SRST)
      state_q == clock_mux_pkg::ST_HIGH && !GUARD_DISABLE_STRAP && !new_rise |=> out_q == 1'b1)
      else $error("high stage not high");
   fall_stage_a: assert property (@(posedge CLK) disable iff (SRST)
      state_q == clock_mux_pkg::ST_FALL && !GUARD_DISABLE_STRAP |=> out_q == 1'b0)
      else $error("fall stage not low");
   old_follow_a: assert property (@(posedge CLK) disable iff (SRST)
      state_q == clock_mux_pkg::ST_OLD && !GUARD_DISABLE_STRAP && !old_fall && !old_stuck |=> out_q == $past(old_lvl))
      else $error("old clock not passed");
   follow_new_a: assert property (@(posedge CLK) disable iff (SRST)
      state_q == clock_mux_pkg::ST_FOLLOW && !GUARD_DISABLE_STRAP && !old_stuck && sel_sync_q == cur_q
      |=> out_q == $past(old_lvl))
      else $error("follow stage not passing");
   hold_lost_a: assert property (@(posedge CLK) disable iff (SRST)
      state_q == clock_mux_pkg::ST_FOLLOW && !GUARD_DISABLE_STRAP && old_stuck && sel_sync_q == cur_q
      |=> $stable(out_q))
      else $error("lost input not held");
   enable_edge_a: assert property (@(posedge CLK) disable iff (SRST)
      !GUARD_DISABLE_STRAP && !sel_fall |=> $stable(en_q))
      else $error("enable moved off edge");
   sync_chain_a: assert property (@(posedge CLK) disable iff (SRST) ##2 sel_sync_q == $past(SEL, 2))
      else $error("select sync wrong");
   // Bounds and entry conditions of the hand-over sequence.
   // The reset check needs no disable, since it looks only at the edge after a reset edge.
   handover_bound_a: assert property (@(posedge CLK) disable iff (SRST)
      state_q != clock_mux_pkg::ST_FOLLOW |-> age_q <= `AGE_W'(`SWITCH_LIMIT_CYCLES))
      else $error("hand-over longer than limit");
   reset_known_a: assert property (@(posedge CLK) SRST
      |=> state_q == clock_mux_pkg::ST_FOLLOW && out_q == 1'b0 && en_q == 1'b0)
      else $error("reset state wrong");
   disabled_low_a: assert property (@(posedge CLK) disable iff (SRST)
      !en_q |-> Q == {`FANOUT_COUNT{1'b0}} && Q_N == {`FANOUT_COUNT{1'b1}})
      else $error("disabled output not low");
   cur_switch_a: assert property (@(posedge CLK) disable iff (SRST)
      !$past(GUARD_DISABLE_STRAP) && $changed(cur_q)
      |-> $past(state_q) == clock_mux_pkg::ST_LOW || $past(state_q) == clock_mux_pkg::ST_FALL)
      else $error("source changed outside hand-over");
   old_hold_a: assert property (@(posedge CLK) disable iff (SRST)
      state_q == clock_mux_pkg::ST_OLD && !GUARD_DISABLE_STRAP && !old_fall && !old_stuck |=> state_q == clock_mux_pkg::ST_OLD)
      else $error("old stage left early");
   enter_handover_a: assert property (@(posedge CLK) disable iff (SRST)
      state_q == clock_mux_pkg::ST_FOLLOW && !GUARD_DISABLE_STRAP && sel_sync_q != cur_q |=> state_q != clock_mux_pkg::ST_FOLLOW)
      else $error("hand-over not entered");
   // ------------------------------------------------------------
   // Cover points
   // ------------------------------------------------------------
   cov_hold_c: cover property (@(posedge CLK) state_q == clock_mux_pkg::ST_FOLLOW && old_stuck ##8 old_stuck);
   cov_normal_c: cover property (@(posedge CLK) state_q == clock_mux_pkg::ST_OLD ##[1:40] state_q == clock_mux_pkg::ST_LOW);
   cov_stuck_c: cover property (@(posedge CLK) state_q == clock_mux_pkg::ST_HIGH ##[1:40] state_q == clock_mux_pkg::ST_FALL);
   cov_bypass_c: cover property (@(posedge CLK) GUARD_DISABLE_STRAP && $changed(SEL));
   cov_disable_c: cover property (@(posedge CLK) en_q ##1 !en_q);
endmodule // clock_switch_mux

/* File: hw/edge_watch.sv */
// Edge and loss detector for one sampled reference clock.
`timescale 1ns/1ps
`include "clock_mux_defines.svh"
module edge_watch (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic clk_in,
   output logic rise,
   output logic fall,
   output logic stuck,
   output logic level_q
);
   logic [`CNT_W-1:0] idle_q;
   logic [`CNT_W-1:0] idle_d;
   logic level_d;
   always_comb begin
      level_d = clk_in;
      if (clk_in != level_q) begin
         idle_d = `CNT_ZERO;
      end else if (idle_q != `CNT_W'(`STUCK_LIMIT)) begin
         idle_d = idle_q + `CNT_ONE;
      end else begin
         idle_d = idle_q;
      end
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         level_q <= 1'b0;
         idle_q <= `CNT_ZERO;
      end else begin
         level_q <= level_d;
         idle_q <= idle_d;
      end
   end
   assign rise = clk_in & ~level_q;
   assign fall = ~clk_in & level_q;
   assign stuck = (idle_q == `CNT_W'(`STUCK_LIMIT));
endmodule // edge_watch
